// file: rtl/lhb_pkg.sv
// constants for the host bus slave of the lan node
// assumes a 100 MHz core clock and a 16-bit expansion bus host
package lhb_pkg;
   localparam int unsigned ADDR_W        = 20;
   localparam int unsigned DATA_W        = 16;
   localparam int unsigned RAM_BYTES     = 2048;
   localparam int unsigned RAM_AW        = 11;
   localparam int unsigned PKT_SLOTS     = 4;
   localparam int unsigned PKT_MAX_BYTES = 508;
   localparam int unsigned SLOT_AW       = 9;
   localparam int unsigned IO_REGS       = 16;
   localparam int unsigned IO_BLK_LSB    = 4;
   localparam int unsigned IO16_LSB      = 2;
   localparam int unsigned IO16_MSB      = 15;
   localparam int unsigned MEM_BLK_LSB   = 14;
   localparam int unsigned ROM_SEL_BIT   = 13;
   // ready stretch time and its cycle count, rounded up
   localparam int unsigned WAIT_NS       = 40;
   localparam int unsigned CLK_NS        = 10;
   localparam int unsigned WAIT_CYC      = (WAIT_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [2:0]  WAIT_CYC_W    = 3'(WAIT_CYC);
   localparam logic [7:0]  REG_RST       = 8'h00;
   localparam logic [15:0] DATA_IDLE     = 16'hffff;
endpackage : lhb_pkg

// file: rtl/lhb_host_slave.sv
// host expansion bus target: io registers, buffer ram, boot memory select
// assumes host strobes asynchronous to clock; open-drain pins resolved
// outside from the output enables
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - direction outputs high for host writes
// - direction low on reads and boot reads
// - ready line only pulled low, else released
// - briefly drop ready to stretch accesses
// - io decode only while aen low
// - memory decode ignores aen
// - latch address and sbhe at bale fall
// - sixteen bit data bus, undriven reads high
// - io read drives selected register
// - io write loads addressed register
// - byte ram of four 512-byte packet slots
// - memory read returns ram or enables boot
// - memory write stores into ram
// - upper byte lanes only with sbhe low
// - io16 select on a15..a2 match
module lhb_host_slave (
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic [19:0] host_addr,
   input  wire logic        host_sbhe_n,
   input  wire logic        host_bale,
   input  wire logic        host_aen,
   input  wire logic        host_ior_n,
   input  wire logic        host_iow_n,
   input  wire logic        host_memr_n,
   input  wire logic        host_memw_n,
   input  wire logic [15:0] host_data_in,
   output logic      [15:0] host_data_out,
   output logic      [15:0] host_data_oe,
   input  wire logic        rom_enable_n,
   input  wire logic [4:0]  mem_base_sel,
   input  wire logic [2:0]  io_base_sel,
   output logic             iochrdy_out,
   output logic             iochrdy_oe,
   output logic             iocs16_n_out,
   output logic             iocs16_n_oe,
   output logic             xcvr_dir_low_byte_n,
   output logic             xcvr_dir_high_byte_n,
   output logic             boot_mem_select_n
);
   // two-stage synchronisers for every input pin
   localparam int unsigned SW = 20 + 1 + 1 + 1 + 4 + 16 + 1 + 5 + 3;
   logic [SW-1:0] sync1_reg;
   logic [SW-1:0] sync2_reg;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sync1_reg <= '1;
         sync2_reg <= '1;
      end else begin
         sync1_reg <= {host_addr,
                       host_sbhe_n,
                       host_bale,
                       host_aen,
                       host_ior_n,
                       host_iow_n,
                       host_memr_n,
                       host_memw_n,
                       host_data_in,
                       rom_enable_n,
                       mem_base_sel,
                       io_base_sel};
         sync2_reg <= sync1_reg;
      end
   end

   logic [19:0] s_addr;
   logic        s_sbhe_n;
   logic        s_bale;
   logic        s_aen;
   logic        s_ior_n;
   logic        s_iow_n;
   logic        s_memr_n;
   logic        s_memw_n;
   logic [15:0] s_data;
   logic        s_rom_en_n;
   logic [4:0]  s_mem_sel;
   logic [2:0]  s_io_sel;

   assign {s_addr,
           s_sbhe_n,
           s_bale,
           s_aen,
           s_ior_n,
           s_iow_n,
           s_memr_n,
           s_memw_n,
           s_data,
           s_rom_en_n,
           s_mem_sel,
           s_io_sel} = sync2_reg;

   // address latch: transparent while bale high, closes on its fall
   logic [19:0] lat_addr_reg;
   logic        lat_sbhe_n_reg;
   logic        bale_d_reg;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         lat_addr_reg   <= 20'h0_0000;
         lat_sbhe_n_reg <= 1'b1;
         bale_d_reg     <= 1'b0;
      end else begin
         bale_d_reg <= s_bale;
         if (s_bale) begin
            lat_addr_reg   <= s_addr;
            lat_sbhe_n_reg <= s_sbhe_n;
         end
      end
   end

   // expected upper address bits of each block
   logic [11:0] io_blk_base;
   logic [13:0] io16_base;
   logic [5:0]  mem_blk_base;

   assign io_blk_base  = {6'h00, 3'h6, s_io_sel};
   assign io16_base    = {io_blk_base, 2'b00};
   assign mem_blk_base = {1'b1, s_mem_sel};

   // decoders
   logic io_blk_hit;
   logic io16_hit;
   logic mem_blk_hit;
   logic ram_hit;
   logic rom_hit;

   always_comb begin
      io_blk_hit  = !s_aen
                    && (lat_addr_reg[lhb_pkg::IO16_MSB:lhb_pkg::IO_BLK_LSB]
                        == io_blk_base);
      io16_hit    = !s_aen
                    && (lat_addr_reg[lhb_pkg::IO16_MSB:lhb_pkg::IO16_LSB]
                        == io16_base);
      mem_blk_hit = lat_addr_reg[19:lhb_pkg::MEM_BLK_LSB] == mem_blk_base;
      ram_hit     = mem_blk_hit && !lat_addr_reg[lhb_pkg::ROM_SEL_BIT];
      rom_hit     = mem_blk_hit && lat_addr_reg[lhb_pkg::ROM_SEL_BIT]
                    && !s_rom_en_n;
   end

   // io register file and buffer ram, byte wide
   logic [7:0] io_regs [lhb_pkg::IO_REGS];
   logic [7:0] ram_mem [lhb_pkg::RAM_BYTES];
   logic [3:0] io_idx;
   logic [10:0] ram_idx;

   assign io_idx   = lat_addr_reg[3:0];
   assign ram_idx  = lat_addr_reg[lhb_pkg::RAM_AW-1:0];

   // write strobe edges
   logic iow_d_reg;
   logic memw_d_reg;
   logic iow_rise;
   logic memw_rise;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         iow_d_reg  <= 1'b1;
         memw_d_reg <= 1'b1;
      end else begin
         iow_d_reg  <= s_iow_n;
         memw_d_reg <= s_memw_n;
      end
   end

   assign iow_rise  = s_iow_n && !iow_d_reg;
   assign memw_rise = s_memw_n && !memw_d_reg;

   logic upper_ok;
   assign upper_ok = !lat_sbhe_n_reg;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         for (int i = 0; i < lhb_pkg::IO_REGS; i++) begin
            io_regs[i] <= lhb_pkg::REG_RST;
         end
      end else if (iow_rise && io_blk_hit) begin
         io_regs[io_idx] <= s_data[7:0];
         if (upper_ok && io_idx != 4'hf) begin
            io_regs[io_idx + 4'h1] <= s_data[15:8];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (memw_rise && ram_hit) begin
         ram_mem[ram_idx] <= s_data[7:0];
         if (upper_ok && ram_idx != 11'h7ff) begin
            ram_mem[ram_idx + 11'h001] <= s_data[15:8];
         end
      end
   end

   // read path
   logic io_rd;
   logic ram_rd;
   logic rom_rd;
   logic [15:0] rd_word;

   assign io_rd  = !s_ior_n && io_blk_hit;
   assign ram_rd = !s_memr_n && ram_hit;
   assign rom_rd = !s_memr_n && rom_hit;

   // lanes the device drives back
   logic rd_low_en;
   logic rd_high_en;

   assign rd_low_en  = io_rd || ram_rd;
   assign rd_high_en = rd_low_en && upper_ok;

   always_comb begin
      rd_word = lhb_pkg::DATA_IDLE;
      if (io_rd) begin
         rd_word[7:0]  = io_regs[io_idx];
         rd_word[15:8] = (io_idx != 4'hf) ? io_regs[io_idx + 4'h1] : 8'hff;
      end else if (ram_rd) begin
         rd_word[7:0]  = ram_mem[ram_idx];
         rd_word[15:8] = (ram_idx != 11'h7ff) ?
                         ram_mem[ram_idx + 11'h001] : 8'hff;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         host_data_out <= lhb_pkg::DATA_IDLE;
         host_data_oe  <= 16'h0000;
      end else begin
         host_data_out <= rd_word;
         host_data_oe  <= {{8{rd_high_en}}, {8{rd_low_en}}};
      end
   end

   // transceiver direction and boot memory select
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         xcvr_dir_low_byte_n  <= 1'b1;
         xcvr_dir_high_byte_n <= 1'b1;
         boot_mem_select_n    <= 1'b1;
      end else begin
         xcvr_dir_low_byte_n  <= !(rd_low_en || rom_rd);
         xcvr_dir_high_byte_n <= !(rd_high_en || rom_rd);
         boot_mem_select_n    <= !rom_rd;
      end
   end

   // ready stretch at the start of each access
   logic [2:0] wait_cnt_reg;
   logic       acc_d_reg;
   logic       acc_now;

   assign acc_now = io_rd || ram_rd || rom_rd
                    || (!s_iow_n && io_blk_hit) || (!s_memw_n && ram_hit);

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wait_cnt_reg <= 3'h0;
         acc_d_reg    <= 1'b0;
      end else begin
         acc_d_reg <= acc_now;
         if (acc_now && !acc_d_reg) begin
            wait_cnt_reg <= lhb_pkg::WAIT_CYC_W;
         end else if (wait_cnt_reg != 3'h0) begin
            wait_cnt_reg <= wait_cnt_reg - 3'h1;
         end
      end
   end

   // channel ready, pulled low only
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         iochrdy_out <= 1'b0;
         iochrdy_oe  <= 1'b0;
      end else begin
         iochrdy_out <= 1'b0;
         iochrdy_oe  <= (acc_now && !acc_d_reg) || (wait_cnt_reg > 3'h1);
      end
   end

   // sixteen bit io select, pulled low only
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         iocs16_n_out <= 1'b0;
         iocs16_n_oe  <= 1'b0;
      end else begin
         iocs16_n_out <= 1'b0;
         iocs16_n_oe  <= io16_hit;
      end
   end

endmodule : lhb_host_slave

`default_nettype wire

// file: testbench/lhb_host_slave_props.sv
// port assertions for the host bus slave
// assumes a bind onto lhb_host_slave, one clock domain
`timescale 1ns/1ps
`default_nettype none
module lhb_props (
   input wire logic        clock,
   input wire logic        sys_rst,
   input wire logic        host_sbhe_n,
   input wire logic        host_bale,
   input wire logic        host_aen,
   input wire logic        host_ior_n,
   input wire logic        host_memr_n,
   input wire logic [15:0] host_data_oe,
   input wire logic        iochrdy_out,
   input wire logic        iochrdy_oe,
   input wire logic        iocs16_n_out,
   input wire logic        iocs16_n_oe,
   input wire logic        xcvr_dir_low_byte_n,
   input wire logic        xcvr_dir_high_byte_n,
   input wire logic        boot_mem_select_n
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   a_dir_idle_high: assert property ((host_ior_n && host_memr_n)[*5]
      |-> xcvr_dir_low_byte_n && xcvr_dir_high_byte_n) else $error("dir low");
   a_pins_only_low: assert property (!iochrdy_out && !iocs16_n_out)
      else $error("open drain driven high");
   a_ready_stretch: assert property ($rose(iochrdy_oe)
      |-> iochrdy_oe[*4] ##1 !iochrdy_oe) else $error("stretch length");
   a_aen_blocks_io: assert property ((host_aen && host_memr_n)[*5]
      |-> host_data_oe == 16'h0000 && !iocs16_n_oe) else $error("io with aen");
   a_upper_sbhe: assert property ((host_bale && host_sbhe_n)[*3]
      ##1 host_sbhe_n[*8] |-> host_data_oe[15:8] == 8'h00)
      else $error("upper lane driven");
   a_read_dir_low: assert property (|host_data_oe[7:0]
      |-> !xcvr_dir_low_byte_n) else $error("low dir wrong");
   a_upper_dir_low: assert property (|host_data_oe[15:8]
      |-> !xcvr_dir_high_byte_n) else $error("high dir wrong");
   a_boot_dir_low: assert property (!boot_mem_select_n
      |-> !xcvr_dir_low_byte_n && !xcvr_dir_high_byte_n) else $error("boot dir");
   c_stretch: cover property ($rose(iochrdy_oe));
   c_boot: cover property ($fell(boot_mem_select_n));
   c_io16: cover property ($rose(iocs16_n_oe));
endmodule : lhb_props
bind lhb_host_slave lhb_props lhb_props_i (.*);
`default_nettype wire

// file: testbench/lhb_host_model.sv
// host processor model driving the expansion bus pins
// assumes pull-ups on data and ready; strobes change at falling edge
`timescale 1ns/1ps
`default_nettype none
module lhb_host_model (
   input  wire logic        clock,
   output var logic [19:0]  host_addr,
   output var logic         host_sbhe_n,
   output var logic         host_bale,
   output var logic         host_aen,
   output logic             host_ior_n,
   output logic             host_iow_n,
   output logic             host_memr_n,
   output logic             host_memw_n,
   output logic [15:0]      host_data_in,
   input  wire logic [15:0] host_data_out,
   input  wire logic [15:0] host_data_oe,
   input  wire logic        iochrdy_oe,
   input  wire logic        xcvr_dir_low_byte_n,
   input  wire logic        xcvr_dir_high_byte_n,
   input  wire logic        boot_mem_select_n
);
   logic [3:0]  st = 4'hf;
   logic [15:0] wd = 16'h0000;
   logic        drv = 1'b0;
   logic [2:0]  seen;
   assign {host_memw_n, host_memr_n, host_iow_n, host_ior_n} = st;
   // undriven lines float high
   assign host_data_in = (host_data_oe & host_data_out)
                       | (~host_data_oe & (drv ? wd : 16'hffff));
   initial begin
      host_addr = 20'h0_0000;
      host_sbhe_n = 1'b1;
      host_bale = 1'b0;
      host_aen = 1'b1;
   end
   task automatic cyc(input logic [1:0] op, input logic [19:0] a,
      input logic sb, aen, input logic [15:0] d,
      output logic [15:0] rd, output logic ok);
      @(negedge clock);
      host_addr = a;
      host_sbhe_n = sb;
      host_aen = aen;
      host_bale = 1'b1;
      repeat (3) @(negedge clock);
      host_bale = 1'b0;
      repeat (2) @(negedge clock);
      host_addr = ~a;
      wd = d;
      drv = op[0];
      st = ~(4'b0001 << op);
      repeat (5) @(negedge clock);
      for (int n = 0; n < 20 && iochrdy_oe; n++) @(negedge clock);
      ok = !iochrdy_oe;
      rd = host_data_in;
      seen = {boot_mem_select_n, xcvr_dir_high_byte_n, xcvr_dir_low_byte_n};
      st = 4'hf;
      repeat (4) @(negedge clock);
      drv = 1'b0;
   endtask : cyc
endmodule : lhb_host_model
`default_nettype wire

// file: testbench/test_lhb_host_slave.sv
// self-checking bench for the host bus slave
// assumes io block sel 2 and memory block sel 1
`timescale 1ns/1ps
`default_nettype none
module test_lhb_host_slave;
   localparam logic [19:0] IOB = 20'h0_0320;
   localparam logic [19:0] MEM = 20'h8_47fe;
   localparam logic [19:0] ROM = 20'h8_6000;
   logic        clock = 1'b0;
   logic        sys_rst, rom_enable_n;
   logic [4:0]  mem_base_sel;
   logic [2:0]  io_base_sel;
   wire  [19:0] host_addr;
   wire  [15:0] host_data_in, host_data_out, host_data_oe;
   wire         host_sbhe_n, host_bale, host_aen, host_ior_n, host_iow_n;
   wire         host_memr_n, host_memw_n, iochrdy_out, iochrdy_oe;
   wire         iocs16_n_out, iocs16_n_oe, boot_mem_select_n;
   wire         xcvr_dir_low_byte_n, xcvr_dir_high_byte_n;
   int          miscompares = 0;
   int          tests_run = 0;
   logic [15:0] rd;
   logic        ok;
   lhb_host_slave lhb_host_slave_i (
      .clock                (clock),
      .sys_rst              (sys_rst),
      .host_addr            (host_addr),
      .host_sbhe_n          (host_sbhe_n),
      .host_bale            (host_bale),
      .host_aen             (host_aen),
      .host_ior_n           (host_ior_n),
      .host_iow_n           (host_iow_n),
      .host_memr_n          (host_memr_n),
      .host_memw_n          (host_memw_n),
      .host_data_in         (host_data_in),
      .host_data_out        (host_data_out),
      .host_data_oe         (host_data_oe),
      .rom_enable_n         (rom_enable_n),
      .mem_base_sel         (mem_base_sel),
      .io_base_sel          (io_base_sel),
      .iochrdy_out          (iochrdy_out),
      .iochrdy_oe           (iochrdy_oe),
      .iocs16_n_out         (iocs16_n_out),
      .iocs16_n_oe          (iocs16_n_oe),
      .xcvr_dir_low_byte_n  (xcvr_dir_low_byte_n),
      .xcvr_dir_high_byte_n (xcvr_dir_high_byte_n),
      .boot_mem_select_n    (boot_mem_select_n)
   );
   lhb_host_model lhb_host_model_i (
      .clock                (clock),
      .host_addr            (host_addr),
      .host_sbhe_n          (host_sbhe_n),
      .host_bale            (host_bale),
      .host_aen             (host_aen),
      .host_ior_n           (host_ior_n),
      .host_iow_n           (host_iow_n),
      .host_memr_n          (host_memr_n),
      .host_memw_n          (host_memw_n),
      .host_data_in         (host_data_in),
      .host_data_out        (host_data_out),
      .host_data_oe         (host_data_oe),
      .iochrdy_oe           (iochrdy_oe),
      .xcvr_dir_low_byte_n  (xcvr_dir_low_byte_n),
      .xcvr_dir_high_byte_n (xcvr_dir_high_byte_n),
      .boot_mem_select_n    (boot_mem_select_n)
   );
   initial begin
      forever #5 clock = ~clock;
   end
   task automatic final_report;
      $display("mismatches %0d of %0d checks", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   task automatic chk(input logic [15:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic go(input logic [1:0] op, input logic [19:0] a,
      input logic sb, aen, input logic [15:0] d);
      lhb_host_model_i.cyc(op, a, sb, aen, d, rd, ok);
      if (ok !== 1'b1) begin
         miscompares++;
         final_report();
      end
   endtask : go
   task automatic t_io;
      go(2'h1, IOB, 1'h0, 1'h0, 16'ha55a);
      chk({13'h0000, lhb_host_model_i.seen}, 16'h0007);
      go(2'h0, IOB, 1'h0, 1'h0, 16'h0000);
      chk(rd, 16'ha55a);
      chk({13'h0000, lhb_host_model_i.seen}, 16'h0004);
      chk({15'h0000, iocs16_n_oe}, 16'h0001);
   endtask : t_io
   task automatic t_aen;
      go(2'h1, IOB, 1'h0, 1'h1, 16'h1234);
      chk({15'h0000, iocs16_n_oe}, 16'h0000);
      go(2'h0, IOB, 1'h0, 1'h1, 16'h0000);
      chk(rd, 16'hffff);
      go(2'h0, IOB, 1'h0, 1'h0, 16'h0000);
      chk(rd, 16'ha55a);
   endtask : t_aen
   task automatic t_mem;
      go(2'h3, MEM, 1'h0, 1'h1, 16'h6c93);
      go(2'h2, MEM, 1'h0, 1'h1, 16'h0000);
      chk(rd, 16'h6c93);
      go(2'h3, MEM, 1'h1, 1'h0, 16'h0011);
      go(2'h2, MEM, 1'h1, 1'h0, 16'h0000);
      chk(rd, 16'hff11);
      go(2'h2, MEM, 1'h0, 1'h0, 16'h0000);
      chk(rd, 16'h6c11);
   endtask : t_mem
   task automatic t_boot;
      @(negedge clock);
      rom_enable_n = 1'b0;
      go(2'h2, ROM, 1'h0, 1'h0, 16'h0000);
      chk({13'h0000, lhb_host_model_i.seen}, 16'h0000);
      @(negedge clock);
      rom_enable_n = 1'b1;
      go(2'h2, ROM, 1'h0, 1'h0, 16'h0000);
      chk({13'h0000, lhb_host_model_i.seen}, 16'h0007);
      chk(rd, 16'hffff);
   endtask : t_boot
   initial begin
      sys_rst = 1'b1;
      rom_enable_n = 1'b1;
      mem_base_sel = 5'h01;
      io_base_sel = 3'h2;
      repeat (6) @(posedge clock);
      @(negedge clock);
      sys_rst = 1'b0;
      repeat (3) @(negedge clock);
      t_io();
      t_aen();
      t_mem();
      t_boot();
      final_report();
   end
endmodule : test_lhb_host_slave
`default_nettype wire
